// ==== src/hirs_pkg.sv ====
// Package with register map, field positions and limits for the host interrupt and rx status block
package hirs_pkg;
  // Register offsets
  localparam logic [7:0]  OFS_IRQ_ENABLE     = 8'h00;
  localparam logic [7:0]  OFS_EVENT_FLAGS    = 8'h02;
  localparam logic [7:0]  OFS_RX_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_RX_CONTROL     = 8'h10;

  // Interrupt flag positions, shared by flag and enable registers
  localparam int          BIT_LINK_CHANGE    = 15;
  localparam int          BIT_TX_DONE        = 14;
  localparam int          BIT_RX_READY       = 13;
  localparam int          BIT_RX_OVERRUN     = 11;
  localparam int          BIT_TX_STOPPED     = 9;
  localparam int          BIT_RX_STOPPED     = 8;
  localparam int          BIT_RX_ERROR       = 7;
  localparam logic [15:0] FLAG_MASK          = 16'hEB80;
  localparam logic [15:0] FLAG_RESET         = 16'h0300;
  localparam logic [15:0] ENABLE_RESET       = 16'h0000;

  // Receive status word fields
  localparam int          RXS_VALID          = 15;
  localparam int          RXS_PORT_HI        = 9;
  localparam int          RXS_PORT_LO        = 8;
  localparam int          RXS_BROADCAST      = 7;
  localparam int          RXS_MULTICAST      = 6;
  localparam int          RXS_UNICAST        = 5;
  localparam int          RXS_ETHERTYPE      = 3;
  localparam int          RXS_OVERSIZE       = 2;
  localparam int          RXS_SHORT          = 1;
  localparam int          RXS_CRC_FAIL       = 0;
  localparam logic [1:0]  PORT_CODE_1        = 2'h1;
  localparam logic [1:0]  PORT_CODE_2        = 2'h2;

  // Receive control: pass-bad-frame position
  localparam int          RXC_PASS_BAD       = 9;
  localparam logic [15:0] RXC_MASK           = 16'h0200;
  localparam logic [15:0] RXC_RESET          = 16'h0000;

  // Frame limits in bytes, broadcast address and group address bit position
  localparam logic [15:0] ETHERTYPE_MIN_LEN  = 16'h05DC;
  localparam logic [10:0] OVERSIZE_LIMIT     = 11'h77C;
  localparam logic [47:0] BROADCAST_ADDR     = 48'hFFFF_FFFF_FFFF;
  localparam int          GROUP_ADDR_BIT     = 40;
endpackage

// ==== src/hirs_top.sv ====
// Host interrupt flags, enables and receive frame status mirror
//
// Overview of operation
// [R1] Interrupt output when any enabled flag set
// [R2] Flags sticky on read, write one clears
// [R3] Bit 15 set on each link change
// [R4] Bit 14 set: frame sent, queue ready
// [R5] Bit 13 set when received frame ready
// [R6] Bit 11 set on receive overrun
// [R7] Bit 9 set on tx stop, resets one
// [R8] Bit 8 set on rx stop, resets one
// [R9] Bit 7 set on errored received frame
// [R10] Rx status read-only, mirrors head frame status
// [R11] Bit 15 one only for valid head frame
// [R12] Bits 9-8 ingress port: 01 or 10
// [R13] Bit 7 marks broadcast destination
// [R14] Bit 6 marks multicast, broadcast included
// [R15] Bit 5 marks unicast destination
// [R16] Bit 3 marks type field above 1500
// [R17] Bit 2 marks length above 1916 bytes
// [R18] Bit 1 marks runt, passed only if allowed
// [R19] Bit 0 marks CRC error, pass-bad gates delivery
// [R20] Per-flag enable at same position, resets zero
// [R21] Reserved bits read zero, writes ignored
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps

module hirs_top #(
  parameter int RX_DEPTH = 4
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // Register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [15:0] o_reg_rdata,
  // Event sources
  input  wire logic        i_link_up,
  input  wire logic        i_tx_frame_sent,
  input  wire logic        i_txq_ready,
  input  wire logic        i_tx_proc_run,
  input  wire logic        i_rx_proc_run,
  // Received frame descriptor from the mac
  input  wire logic        i_rx_frame_done,
  input  wire logic        i_rx_port_sel,
  input  wire logic [47:0] i_rx_dest_addr,
  input  wire logic [15:0] i_rx_type_len,
  input  wire logic [10:0] i_rx_length,
  input  wire logic        i_rx_runt,
  input  wire logic        i_rx_crc_err,
  // Receive queue head release from the queue manager
  input  wire logic        i_rx_release,
  // Outputs
  output logic             o_rx_accept,
  output logic             o_irq
);

  localparam int PW = $clog2(RX_DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("RX_DEPTH must be a power of two, at least 2");
  end

  logic [15:0]   flags_q;
  logic [15:0]   enable_q;
  logic [15:0]   rx_ctrl_q;
  logic [15:0]   ev_set;
  logic [15:0]   ev_clr;
  logic          link_q;
  logic          tx_run_q;
  logic          rx_run_q;
  logic          tx_pend_q;
  logic          tx_event;
  logic [15:0]   new_status;
  logic          rx_bad;
  logic          rx_keep;
  logic          rx_push;
  logic          rx_pop;
  logic          rx_full;
  logic          rx_empty;
  logic [PW:0]   count_q;
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [15:0]   status_mem [RX_DEPTH];
  logic [15:0]   head_status;

  // Receive status word built from the frame descriptor
  always_comb begin
    new_status = 16'h0000;
    new_status[hirs_pkg::RXS_PORT_HI:hirs_pkg::RXS_PORT_LO] =
      i_rx_port_sel ? hirs_pkg::PORT_CODE_2 : hirs_pkg::PORT_CODE_1; // R12
    new_status[hirs_pkg::RXS_BROADCAST] = (i_rx_dest_addr == hirs_pkg::BROADCAST_ADDR); // R13
    new_status[hirs_pkg::RXS_MULTICAST] = i_rx_dest_addr[hirs_pkg::GROUP_ADDR_BIT]; // R14
    new_status[hirs_pkg::RXS_UNICAST]   = ~i_rx_dest_addr[hirs_pkg::GROUP_ADDR_BIT]; // R15
    // Meaningless for runts, still reported as computed
    new_status[hirs_pkg::RXS_ETHERTYPE] = (i_rx_type_len > hirs_pkg::ETHERTYPE_MIN_LEN); // R16
    new_status[hirs_pkg::RXS_OVERSIZE]  = (i_rx_length > hirs_pkg::OVERSIZE_LIMIT); // R17
    new_status[hirs_pkg::RXS_SHORT]     = i_rx_runt; // R18
    new_status[hirs_pkg::RXS_CRC_FAIL]  = i_rx_crc_err; // R19
  end

  assign rx_bad   = new_status[hirs_pkg::RXS_OVERSIZE] | new_status[hirs_pkg::RXS_SHORT]
                  | new_status[hirs_pkg::RXS_CRC_FAIL];
  // Bad frames delivered only with pass-bad-frame set
  assign rx_keep  = ~rx_bad | rx_ctrl_q[hirs_pkg::RXC_PASS_BAD]; // R17 R18 R19
  assign rx_full  = (count_q == RX_DEPTH[PW:0]);
  assign rx_empty = (count_q == '0);
  assign rx_push  = i_rx_frame_done & rx_keep & ~rx_full;
  assign rx_pop   = i_rx_release & ~rx_empty;
  assign o_rx_accept = ~rx_full;

  // Status queue; one word per frame held in the receive queue
  always_ff @(posedge i_core_clk) begin
    if (rx_push) begin
      status_mem[wr_ptr_q] <= new_status;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (rx_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (rx_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (rx_push && !rx_pop) begin
        count_q <= count_q + 1'b1;
      end else if (rx_pop && !rx_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // Valid bit only while a completed frame sits at the head
  always_comb begin
    head_status = 16'h0000;
    if (!rx_empty) begin
      head_status = status_mem[rd_ptr_q]; // R10
      head_status[hirs_pkg::RXS_VALID] = 1'b1; // R11
    end
  end

  // Edge history for level sources
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      link_q   <= 1'b0;
      tx_run_q <= 1'b0;
      rx_run_q <= 1'b0;
    end else begin
      link_q   <= i_link_up;
      tx_run_q <= i_tx_proc_run;
      rx_run_q <= i_rx_proc_run;
    end
  end

  // A sent frame is remembered until the queue can take more
  assign tx_event = (tx_pend_q | i_tx_frame_sent) & i_txq_ready; // R4

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      tx_pend_q <= 1'b0;
    end else if (tx_event) begin
      tx_pend_q <= 1'b0;
    end else if (i_tx_frame_sent) begin
      tx_pend_q <= 1'b1;
    end
  end

  always_comb begin
    ev_set = 16'h0000;
    ev_set[hirs_pkg::BIT_LINK_CHANGE] = (link_q != i_link_up); // R3
    ev_set[hirs_pkg::BIT_TX_DONE]     = tx_event; // R4
    ev_set[hirs_pkg::BIT_RX_READY]    = rx_push; // R5
    ev_set[hirs_pkg::BIT_RX_OVERRUN]  = i_rx_frame_done & rx_keep & rx_full; // R6
    ev_set[hirs_pkg::BIT_TX_STOPPED]  = tx_run_q & ~i_tx_proc_run; // R7
    ev_set[hirs_pkg::BIT_RX_STOPPED]  = rx_run_q & ~i_rx_proc_run; // R8
    ev_set[hirs_pkg::BIT_RX_ERROR]    = i_rx_frame_done & rx_bad; // R9
  end

  // Write one clears; a same-cycle event keeps the flag set
  assign ev_clr = (i_reg_wr && i_reg_addr == hirs_pkg::OFS_EVENT_FLAGS) ? i_reg_wdata : 16'h0000; // R2

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      flags_q <= hirs_pkg::FLAG_RESET; // R7 R8
    end else begin
      flags_q <= ((flags_q & ~ev_clr) | ev_set) & hirs_pkg::FLAG_MASK; // R2 R21
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      enable_q <= hirs_pkg::ENABLE_RESET; // R20
    end else if (i_reg_wr && i_reg_addr == hirs_pkg::OFS_IRQ_ENABLE) begin
      enable_q <= i_reg_wdata & hirs_pkg::FLAG_MASK; // R20
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rx_ctrl_q <= hirs_pkg::RXC_RESET;
    end else if (i_reg_wr && i_reg_addr == hirs_pkg::OFS_RX_CONTROL) begin
      rx_ctrl_q <= i_reg_wdata & hirs_pkg::RXC_MASK;
    end
  end

  assign o_irq = |(flags_q & enable_q); // R1

  // Read data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        hirs_pkg::OFS_IRQ_ENABLE:  o_reg_rdata <= enable_q;
        hirs_pkg::OFS_EVENT_FLAGS: o_reg_rdata <= flags_q; // R2
        hirs_pkg::OFS_RX_STATUS:   o_reg_rdata <= head_status; // R10
        hirs_pkg::OFS_RX_CONTROL:  o_reg_rdata <= rx_ctrl_q;
        default:                   o_reg_rdata <= 16'h0000;
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end

endmodule

// ==== testbench/hirs_chk_sva.sv ====
// Checker for the host interrupt flags and rx status mirror
`timescale 1ns/1ps
module hirs_chk (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  // Register port and sources
  input wire logic [7:0]  i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        i_link_up,
  input wire logic        i_rx_proc_run,
  input wire logic        o_irq
);
  logic       rd_q;
  logic [7:0] ra_q;
  always_ff @(posedge i_core_clk) begin
    rd_q <= i_reg_rd;
    ra_q <= i_reg_addr;
  end
  wire flg = rd_q && ra_q == 8'h02;
  wire rxs = rd_q && ra_q == 8'h04;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  a_rdata_idle: assert property (!rd_q |-> o_reg_rdata == 16'h0000) else $error("read data not idle");
  a_flag_reserved: assert property (flg |-> (o_reg_rdata & 16'h147F) == 16'h0000) else $error("flag gap set");
  a_rxs_reserved: assert property (rxs |-> (o_reg_rdata & 16'h7C10) == 16'h0000) else $error("rx gap set");
  a_port_code: assert property (rxs && o_reg_rdata[15] |-> ^o_reg_rdata[9:8]) else $error("bad port code");
  a_bcast_multi: assert property (rxs && o_reg_rdata[7] |-> o_reg_rdata[6]) else $error("bcast not group");
  a_uni_multi: assert property (rxs && o_reg_rdata[15] |-> o_reg_rdata[6] != o_reg_rdata[5]) else $error("uni");
  a_link_flag: assert property ($changed(i_link_up) ##1 (i_reg_rd && i_reg_addr == 8'h02)
    |=> o_reg_rdata[15]) else $error("link flag missing");
  a_irq_disable: assert property (i_reg_wr && i_reg_addr == 8'h00 && i_reg_wdata == 16'h0000
    |=> !o_irq) else $error("irq with no enables");
  a_w1c_clear: assert property ((i_reg_wr && i_reg_addr == 8'h02 && i_reg_wdata[8] && !i_rx_proc_run
    && !$past(i_rx_proc_run)) ##1 (i_reg_rd && i_reg_addr == 8'h02 && !i_rx_proc_run)
    |=> !o_reg_rdata[8]) else $error("flag not cleared");
  c_rx_valid: cover property (rxs && o_reg_rdata[15]);
  c_irq: cover property (o_irq);
  c_link: cover property ($changed(i_link_up));
endmodule

// ==== testbench/hirs_host_model.sv ====
// Host processor model driving the register port
`timescale 1ns/1ps
module hirs_host_model (
  // Clock
  input  wire logic        i_core_clk,
  // Register port
  output logic      [7:0]  o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd,
  input  wire logic [15:0] i_rdata
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Entered just after an edge; ones in the data clear flags
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    // Data stands until this edge; sampled before it is cleared
    @(posedge i_core_clk);
    d = i_rdata;
  endtask
endmodule

// ==== testbench/hirs_tb_top.sv ====
// Testbench for the host interrupt flags and rx status mirror
`timescale 1ns/1ps
module hirs_tb_top;
  logic        clk = 0, rst = 1, link = 0, sent = 0, txr = 0, txrun = 0, rxrun = 0;
  logic        done = 0, port = 0, runt = 0, crc = 0, rel = 0, wr, rd, acc, irq;
  logic [47:0] da = '0;
  logic [15:0] tl = '0, wdata, rdata, v;
  logic [10:0] len = '0;
  logic [7:0]  addr;
  int          num_errors = 0, n_compared = 0, cyc = 0;
  hirs_host_model host_u (.i_core_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
  hirs_top dut_u (.i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_link_up(link), .i_tx_frame_sent(sent), .i_txq_ready(txr),
    .i_tx_proc_run(txrun), .i_rx_proc_run(rxrun), .i_rx_frame_done(done), .i_rx_port_sel(port),
    .i_rx_dest_addr(da), .i_rx_type_len(tl), .i_rx_length(len), .i_rx_runt(runt), .i_rx_crc_err(crc),
    .i_rx_release(rel), .o_rx_accept(acc), .o_irq(irq));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rchk(string n, logic [7:0] a, logic [15:0] e);
    host_u.rd(a, v);
    chk(n, e, v);
  endtask
  task automatic frame(logic p, logic [47:0] d, logic [15:0] t, logic [10:0] l, logic r, logic c);
    @(posedge clk);
    {done, port, da, tl, len, runt, crc} <= {1'b1, p, d, t, l, r, c};
    @(posedge clk);
    done <= 1'b0;
  endtask
  task automatic t_reset;
    rchk("flags", 8'h02, 16'h0300);
    rchk("enables", 8'h00, 16'h0000);
    rchk("unmapped", 8'h0E, 16'h0000);
    rchk("rxstat", 8'h04, 16'h0000);
    $display("t_reset end");
  endtask
  task automatic t_w1c;
    host_u.wr(8'h02, 16'h0000);
    rchk("flags", 8'h02, 16'h0300);
    host_u.wr(8'h02, 16'h0100);
    rchk("flags", 8'h02, 16'h0200);
    host_u.wr(8'h02, 16'hFFFF);
    rchk("flags", 8'h02, 16'h0000);
    $display("t_w1c end");
  endtask
  task automatic t_events;
    @(posedge clk) link <= 1'b1;
    @(posedge clk);
    rchk("link up", 8'h02, 16'h8000);
    host_u.wr(8'h02, 16'hFFFF);
    link <= 1'b0;
    @(posedge clk);
    rchk("link down", 8'h02, 16'h8000);
    host_u.wr(8'h02, 16'hFFFF);
    {txr, sent, txrun, rxrun} <= 4'hF;
    @(posedge clk) sent <= 1'b0;
    {txrun, rxrun} <= 2'h0;
    @(posedge clk);
    rchk("tx rx stop", 8'h02, 16'h4300);
    host_u.wr(8'h02, 16'hFFFF);
    $display("t_events end");
  endtask
  task automatic t_irq;
    host_u.wr(8'h00, 16'hFFFF);
    rchk("enables", 8'h00, 16'hEB80);
    link <= 1'b1;
    @(posedge clk);
    #1 chk("irq on", 16'h0001, 16'(irq));
    host_u.wr(8'h00, 16'h4000);
    #1 chk("irq masked", 16'h0000, 16'(irq));
    host_u.wr(8'h02, 16'hFFFF);
    $display("t_irq end");
  endtask
  task automatic t_rx;
    frame(1'b0, '1, 16'h0600, 11'h040, 1'b0, 1'b0);
    rchk("rx ready", 8'h02, 16'h2000);
    host_u.wr(8'h04, 16'h0000);
    rchk("bcast", 8'h04, 16'h81C8);
    @(posedge clk) rel <= 1'b1;
    @(posedge clk) rel <= 1'b0;
    rchk("empty", 8'h04, 16'h0000);
    host_u.wr(8'h02, 16'hFFFF);
    frame(1'b1, 48'h0200_0000_0001, 16'h05DC, 11'h77D, 1'b1, 1'b1);
    rchk("dropped", 8'h02, 16'h0080);
    rchk("not kept", 8'h04, 16'h0000);
    host_u.wr(8'h10, 16'h0200);
    frame(1'b1, 48'h0200_0000_0001, 16'h05DC, 11'h77D, 1'b1, 1'b1);
    rchk("bad kept", 8'h04, 16'h8227);
    host_u.wr(8'h02, 16'hFFFF);
    repeat (3) frame(1'b0, 48'h0100_0000_0000, 16'h0040, 11'h040, 1'b0, 1'b0);
    #1 chk("full", 16'h0000, 16'(acc));
    frame(1'b0, 48'h0100_0000_0000, 16'h0040, 11'h040, 1'b0, 1'b0);
    rchk("overrun", 8'h02, 16'h2800);
    $display("t_rx end");
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_w1c();
    t_events();
    t_irq();
    t_rx();
    report_and_stop();
  end
endmodule
bind hirs_top hirs_chk chk_u (.*);
